// *** dv/core_model.sv ***
// processor core stand-in: accepts events and returns them
module core_model (
   input  logic        pclk,
   input  logic        presetn,
   input  logic        slow,
   input  logic        service_valid,
   input  logic [3:0]  service_id,
   output logic        core_ready,
   output logic [15:0] event_return
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] active;
   logic [1:0]  cnt;
   wire  [15:0] low  = active & (~active + 16'h0001);
   wire         fire = active != 16'h0000 && !slow && cnt == 2'h3;
   wire  [15:0] acc  = service_valid ? 16'h0001 << service_id : 16'h0000;
   assign core_ready = !slow || cnt[0];
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         active <= 16'h0000;
         cnt <= 2'h0;
         event_return <= 16'h0000;
      end else begin
         cnt <= cnt + 2'h1;
         event_return <= fire ? low : 16'h0000; // innermost nested first
         active <= (active & ~(fire ? low : 16'h0000)) | acc;
      end
   end
endmodule

// *** dv/event_ctrl_asserts.sv ***
// property checks on the event controller ports
module event_ctrl_asserts (
   input logic        pclk,
   input logic        presetn,
   input logic        pce,
   input logic        psel,
   input logic        penable,
   input logic [11:0] paddr,
   input logic        pslverr,
   input logic        supervisor,
   input logic        global_irq_enable_instr,
   input logic        global_irq_disable_instr,
   input logic        service_valid,
   input logic [3:0]  service_id,
   input logic [15:0] event_pending,
   input logic [15:0] event_return,
   input logic        global_irq_enable
);
   timeunit 1ns;
   timeprecision 1ps;
   wire [15:0] upto = (16'h0002 << service_id) - 16'h0001;
   wire [15:0] live = event_pending & ~event_return;
   wire        dis  = pce && global_irq_disable_instr && !global_irq_enable_instr;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ---------------------------------------------------------------
   // sequences and properties
   // ---------------------------------------------------------------
   sequence access_s;
      psel && penable;
   endsequence
   sequence returned_s;
      pce && event_return != 16'h0000 ##1 !service_valid;
   endsequence
   rst_clear_a: assert property ($rose(presetn) |-> event_pending == 16'h0000)
      else $error("pending set just after reset");
   svc_prio_a: assert property (service_valid |-> ($past(live) & upto) == 16'h0000)
      else $error("accepted event not above all pending");
   pend_hw_a: assert property (|(event_pending & ~$past(event_pending)) |->
      service_valid) else $error("pending rose without acceptance");
   ret_clr_a: assert property (returned_s |->
      (event_pending & $past(event_return)) == 16'h0000) else $error("return left pending");
   gie_on_a: assert property (pce && global_irq_enable_instr |=> global_irq_enable)
      else $error("enable instruction ignored");
   gie_off_a: assert property (dis |=> !global_irq_enable)
      else $error("disable instruction ignored");
   gie_gate_a: assert property (service_valid && service_id > 4'h6 |->
      $past(global_irq_enable)) else $error("level served while globally disabled");
   mask_err_a: assert property ((access_s and (paddr == 12'h004 && !supervisor)) |->
      pslverr) else $error("mask access outside supervisor not refused");
endmodule

bind event_ctrl event_ctrl_asserts u_chk (
   .pclk, .presetn, .pce, .psel, .penable, .paddr, .pslverr, .supervisor,
   .global_irq_enable_instr, .global_irq_disable_instr, .service_valid,
   .service_id, .event_pending, .event_return, .global_irq_enable
);

// *** dv/tb.sv ***
// self-checking bench for the event controller
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        pclk = 1'h0, presetn = 1'h0, supervisor = 1'h1, slow = 1'h0, pce = 1'h1;
   logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic        global_irq_enable_instr = 1'h0, global_irq_disable_instr = 1'h0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata;
   logic        pready, pslverr, core_ready, service_valid, global_irq_enable;
   logic [55:0] periph_irq = 56'h0;
   logic [15:0] core_event_in = 16'h0, event_return, event_pending;
   logic [15:0] lfsr = 16'h6408;
   logic [3:0]  service_id, lv;
   logic [32:0] apb_q[$];
   logic [19:0] svc_q[$];
   logic [31:0] route_rst[7] = '{32'h00000000, 32'h11000000, 32'h33332222,
      32'h44444433, 32'h55555555, 32'h06666655, 32'h33333000};
   int          mismatches = 0, cmp_count = 0, n;
   always #5 pclk = ~pclk;
   event_ctrl u_dut (.pclk, .presetn, .pce, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .periph_irq, .core_event_in, .supervisor,
      .global_irq_enable_instr, .global_irq_disable_instr, .core_ready, .event_return,
      .service_valid, .service_id, .event_pending, .global_irq_enable);
   core_model u_core (.pclk, .presetn, .slow, .service_valid, .service_id, .core_ready,
      .event_return);
   // ---------------------------------------------------------------
   // checking and bus tasks
   // ---------------------------------------------------------------
   task automatic chk(input string nm, input logic [32:0] seen, input logic [32:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic summarize;
      $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
      if (mismatches == 0 && cmp_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   function automatic logic [15:0] nxt(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [32:0] e);
      @(posedge pclk);
      apb_q.push_back(e);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      n = 0;
      do begin @(posedge pclk); n++; end while (pready !== 1'h1 && n < 20);
      if (n == 20) chk("pready", 0, 1);
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'h1, a, d, 33'h0);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      apb(1'h0, a, 32'h0, {1'h0, e});
   endtask
   task automatic pulse(input int b);
      @(posedge pclk);
      core_event_in[b] <= 1'h1;
      @(posedge pclk);
      core_event_in[b] <= 1'h0;
   endtask
   task automatic gie(input logic on);
      @(posedge pclk);
      global_irq_enable_instr <= on;
      global_irq_disable_instr <= !on;
      @(posedge pclk);
      global_irq_enable_instr <= 1'h0;
      global_irq_disable_instr <= 1'h0;
   endtask
   task automatic settle;
      n = 0;
      while ((svc_q.size() != 0 || (event_pending !== 16'h0 && !slow)) && n < 200) begin
         @(posedge pclk);
         n++;
      end
      if (n == 200) chk("settle", 0, 1);
   endtask
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'h1)
         chk("apb", {pslverr, pwrite ? 32'h0 : prdata}, apb_q.size() ? apb_q.pop_front() : 33'hx);
      if (service_valid === 1'h1)
         chk("svc", {event_pending, service_id}, svc_q.size() ? svc_q.pop_front() : 20'hx);
   end
   initial begin
      #100us;
      mismatches++;
      summarize();
   end
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'h1;
      rd(12'h000, 0);
      rd(12'h008, 0);
      for (int r = 0; r < 7; r++) rd(12'h020 + 4 * r, route_rst[r]);
      supervisor <= 1'h0;
      apb(1'h0, 12'h004, 32'h0, 33'h100000000);
      apb(1'h1, 12'h004, 32'hffff, 33'h100000000);
      apb(1'h0, 12'h008, 32'h0, 33'h100000000);
      supervisor <= 1'h1;
      apb(1'h1, 12'h008, 32'hffff, 33'h100000000);
      rd(12'h004, 0);
      lfsr = nxt(lfsr);
      wr(12'h000, lfsr);
      rd(12'h000, lfsr);
      wr(12'h000, 0);
      pulse(9);
      rd(12'h000, 32'h200);
      gie(1'h0);
      wr(12'h004, 32'h600);
      pulse(10);
      rd(12'h000, 32'h600);
      rd(12'h00c, 0);
      svc_q.push_back({16'h0200, 4'h9});
      svc_q.push_back({16'h0400, 4'ha});
      gie(1'h1);
      rd(12'h00c, 1);
      settle;
      rd(12'h000, 0);
      wr(12'h004, 32'hff80);
      svc_q.push_back({16'h1000, 4'hc});
      @(posedge pclk);
      core_event_in[12] <= 1'h1;
      repeat (2) @(posedge pclk);
      #1 chk("early", service_valid, 0);
      @(posedge pclk);
      #1 chk("on time", service_valid, 1);
      settle;
      core_event_in[12] <= 1'h0;
      slow <= 1'h1;
      svc_q.push_back({16'h2000, 4'hd});
      svc_q.push_back({16'h2100, 4'h8});
      pulse(13);
      pulse(8);
      settle;
      slow <= 1'h0;
      settle;
      wr(12'h018, 32'hffffffff);
      wr(12'h01c, 32'h00ffffff);
      for (int p = 0; p < 56; p++) begin
         lv = route_rst[p / 8][4 * (p % 8) +: 4];
         svc_q.push_back({16'h0080 << lv, 4'h7 + lv});
         @(posedge pclk);
         periph_irq[p] <= 1'h1;
         repeat (2) @(posedge pclk);
         rd(p < 32 ? 12'h010 : 12'h014, 32'h1 << (p % 32));
         settle;
         periph_irq[p] <= 1'h0;
         repeat (3) @(posedge pclk);
      end
      wr(12'h020, 32'h00000076);
      rd(12'h020, 32'h00000076);
      svc_q.push_back({16'h2000, 4'hd});
      @(posedge pclk);
      periph_irq[1:0] <= 2'h3;
      settle;
      periph_irq[1:0] <= 2'h0;
      pce <= 1'h0;
      gie(1'h0);
      pce <= 1'h1;
      #1 chk("frozen", global_irq_enable, 1);
      apb(1'h1, 12'h00c, 32'h0, 33'h100000000);
      rd(12'h00c, 1);
      apb(1'h0, 12'h022, 32'h0, 33'h100000000);
      apb(1'h0, 12'h03c, 32'h0, 33'h100000000);
      rd(12'h018, 32'hffffffff);
      rd(12'h01c, 32'h00ffffff);
      @(posedge pclk);
      presetn <= 1'h0;
      repeat (4) @(posedge pclk);
      presetn <= 1'h1;
      rd(12'h004, 0);
      rd(12'h020, 0);
      summarize;
   end
endmodule

// *** logic/event_ctrl.v ***
// core event latch, mask and pending logic with peripheral routing stage
//
// Contract
// - three 16-bit registers latch, mask and pending, one bit per event
// - latch bit sets when the event has been captured
// - latch bit clears by itself once the event is accepted
// - latch writes only affect bits whose mask bit is clear
// - mask bit one lets the event be serviced when asserted
// - mask bit zero blocks service but the event still latches
// - mask register read and write only in supervisor mode
// - global enable set and cleared by instructions, gates general-purpose levels
// - pending holds every active or nested event
// - pending changed only by hardware, readable in supervisor mode
// - reset routes peripherals 0 to 13 to level 7
// - reset routes 14 and 15 to level 8, 16 to 19 to level 9
// - reset routes peripherals 20 to 25 to level 10
// - reset routes peripherals 26 to 31 to level 11
// - reset routes 32 to 41 to level 12, 42 to 46 to level 13
// - reset routes 47 to 50 to level 7, 51 to 55 to level 10
// - peripherals 0 to 31 use mask and status 0, 32 to 55 use set 1
// - seven assignment registers, eight peripheral fields each, from register 0
// - latch sets two cycles after a rising edge, clears when pending sets
// - rising edge to pending takes at least three cycles
// - status bit reads one while its peripheral requests
// - software rewrites routing through the assignment registers
`include "event_map.vh"

module event_ctrl (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        pce,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire [55:0] periph_irq,
   input  wire [15:0] core_event_in,
   input  wire        supervisor,
   input  wire        global_irq_enable_instr,
   input  wire        global_irq_disable_instr,
   input  wire        core_ready,
   input  wire [15:0] event_return,
   output reg         service_valid,
   output reg  [3:0]  service_id,
   output reg  [15:0] event_pending,
   output reg         global_irq_enable
);

   // ---------------------------------------------------------------
   // functions
   // ---------------------------------------------------------------
   // index of the highest-priority (lowest-numbered) set bit, 16 if none
   function [4:0] first_set;
      input [15:0] vec;
      integer k;
      begin
         first_set = 5'h10;
         for (k = 15; k >= 0; k = k - 1) begin
            if (vec[k]) begin
               first_set = k[4:0];
            end
         end
      end
   endfunction

   // one-hot from index, zero when index is 16
   function [15:0] onehot;
      input [4:0] idx;
      begin
         onehot = 16'h0000;
         if (!idx[4]) begin
            onehot[idx[3:0]] = 1'b1;
         end
      end
   endfunction

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   reg  [15:0]  latch_reg;
   reg  [15:0]  mask_reg;
   reg  [15:0]  pend_reg;
   reg  [55:0]  irq_meta_reg;
   reg  [55:0]  irq_sync_reg;
   reg  [31:0]  pmask0_reg;
   reg  [31:0]  pmask1_reg;
   reg  [223:0] route_reg;

   reg  [15:0]  latch_next;
   reg  [15:0]  pend_next;
   reg  [31:0]  rdata_next;
   reg          err_next;

   wire [6:0]   gp_req;
   wire [15:0]  rise;
   wire [15:0]  level_all;
   wire [15:0]  eligible;
   wire [4:0]   cand_idx;
   wire [4:0]   top_idx;
   wire         take;
   wire [15:0]  pend_set;
   wire         setup;
   wire         access;
   wire         wr_ok;
   wire [2:0]   route_sel;
   wire         route_hit;
   wire [11:0]  route_off;
   wire [15:0]  gate;
   wire         wr_latch;
   wire         wr_mask;
   wire         wr_pmask0;
   wire         wr_pmask1;
   wire         wr_route;

   // ---------------------------------------------------------------
   // peripheral pin synchroniser
   // ---------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_meta_reg <= 56'h00000000000000;
         irq_sync_reg <= 56'h00000000000000;
      end else if (pce) begin
         irq_meta_reg <= periph_irq;
         irq_sync_reg <= irq_meta_reg;
      end
   end

   // ---------------------------------------------------------------
   // routing stage
   // ---------------------------------------------------------------
   periph_router u_router (
      .periph_level (irq_sync_reg),
      .periph_mask  ({pmask1_reg[23:0], pmask0_reg}),
      .route_fields (route_reg),
      .gp_req       (gp_req)
   );

   assign level_all = core_event_in | {2'b00, gp_req, 7'h00};

   rise_detect u_rise (
      .pclk     (pclk),
      .presetn  (presetn),
      .pce      (pce),
      .level_in (level_all),
      .rise_q   (rise)
   );

   // ---------------------------------------------------------------
   // service selection
   // ---------------------------------------------------------------
   // masked events stay latched but are never picked
   assign gate     = global_irq_enable ? 16'hffff : ~`GP_GATE_MASK;
   assign eligible = latch_reg & mask_reg & gate;
   assign cand_idx = first_set(eligible);
   assign top_idx  = first_set(pend_reg);
   // a new event nests only above every active one
   assign take     = core_ready && !cand_idx[4] && (cand_idx < top_idx);
   assign pend_set = take ? onehot(cand_idx) : 16'h0000;

   // ---------------------------------------------------------------
   // bus phases and decode
   // ---------------------------------------------------------------
   assign setup     = psel && !penable;
   assign access    = psel && penable && pready;
   assign wr_ok     = access && pwrite && !pslverr;
   assign route_off = paddr - `OFF_ROUTE_0;
   assign route_hit = (paddr >= `OFF_ROUTE_0) && (paddr <= `OFF_ROUTE_6)
                      && (paddr[1:0] == 2'b00);
   assign route_sel = route_off[4:2];

   // ---------------------------------------------------------------
   // write strobes, only for accepted transfers
   // ---------------------------------------------------------------
   assign wr_latch  = wr_ok && (paddr == `OFF_LATCH);
   assign wr_mask   = wr_ok && (paddr == `OFF_MASK);
   assign wr_pmask0 = wr_ok && (paddr == `OFF_PMASK_0);
   assign wr_pmask1 = wr_ok && (paddr == `OFF_PMASK_1);
   assign wr_route  = wr_ok && route_hit;

   always @* begin
      rdata_next = 32'h00000000;
      err_next   = 1'b0;
      if (paddr == `OFF_LATCH) begin
         rdata_next = {16'h0000, latch_reg};
      end else if (paddr == `OFF_MASK) begin
         if (supervisor) begin
            rdata_next = {16'h0000, mask_reg};
         end else begin
            err_next = 1'b1;
         end
      end else if (paddr == `OFF_PENDING) begin
         if (supervisor && !pwrite) begin
            rdata_next = {16'h0000, pend_reg};
         end else begin
            err_next = 1'b1;
         end
      end else if (paddr == `OFF_CONTROL) begin
         rdata_next = {31'h00000000, global_irq_enable};
         err_next   = pwrite;
      end else if (paddr == `OFF_PSTATUS_0) begin
         rdata_next = irq_sync_reg[31:0];
         err_next   = pwrite;
      end else if (paddr == `OFF_PSTATUS_1) begin
         rdata_next = {8'h00, irq_sync_reg[55:32]};
         err_next   = pwrite;
      end else if (paddr == `OFF_PMASK_0) begin
         rdata_next = pmask0_reg;
      end else if (paddr == `OFF_PMASK_1) begin
         rdata_next = pmask1_reg;
      end else if (route_hit) begin
         rdata_next = route_reg[route_sel*32 +: 32];
      end else begin
         err_next = 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // bus answer, zero wait states
   // ---------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
      end else if (pce) begin
         pready  <= setup;
         pslverr <= setup && err_next;
         if (setup && !pwrite) begin
            prdata <= rdata_next;
         end else if (access) begin
            prdata <= 32'h00000000;
         end
      end
   end

   // ---------------------------------------------------------------
   // latch and pending next state
   // ---------------------------------------------------------------
   always @* begin
      latch_next = latch_reg;
      if (wr_latch) begin
         latch_next = (latch_reg & mask_reg) | (pwdata[15:0] & ~mask_reg);
      end
      latch_next = latch_next & ~pend_set;
      latch_next = latch_next | rise;
      pend_next  = (pend_reg & ~event_return) | pend_set;
   end

   // ---------------------------------------------------------------
   // latch register
   // ---------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         latch_reg <= `RST_LATCH;
      end else if (pce) begin
         latch_reg <= latch_next;
      end
   end

   // ---------------------------------------------------------------
   // pending register
   // ---------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend_reg <= `RST_PENDING;
      end else if (pce) begin
         pend_reg <= pend_next;
      end
   end

   // ---------------------------------------------------------------
   // mask register, written only through an accepted transfer
   // ---------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_reg <= `RST_MASK;
      end else if (pce && wr_mask) begin
         mask_reg <= pwdata[15:0];
      end
   end

   // ---------------------------------------------------------------
   // global enable
   // ---------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         global_irq_enable <= 1'b0;
      end else if (pce) begin
         if (global_irq_enable_instr) begin
            global_irq_enable <= 1'b1;
         end else if (global_irq_disable_instr) begin
            global_irq_enable <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // peripheral mask and assignment registers
   // ---------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pmask0_reg <= `RST_PMASK;
         pmask1_reg <= `RST_PMASK;
         route_reg  <= {`RST_ROUTE_6,
                        `RST_ROUTE_5,
                        `RST_ROUTE_4,
                        `RST_ROUTE_3,
                        `RST_ROUTE_2,
                        `RST_ROUTE_1,
                        `RST_ROUTE_0};
      end else if (pce) begin
         if (wr_pmask0) begin
            pmask0_reg <= pwdata;
         end
         if (wr_pmask1) begin
            pmask1_reg <= {8'h00, pwdata[23:0]};
         end
         if (wr_route) begin
            route_reg[route_sel*32 +: 32] <= pwdata;
         end
      end
   end

   // ---------------------------------------------------------------
   // outputs to the core
   // ---------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         service_valid <= 1'b0;
         service_id    <= 4'h0;
         event_pending <= `RST_PENDING;
      end else if (pce) begin
         service_valid <= take;
         service_id    <= cand_idx[3:0];
         event_pending <= pend_next;
      end
   end

endmodule

// *** logic/event_map.vh ***
// register offsets, field layout and reset values of the event controller
`ifndef EVENT_MAP_VH
`define EVENT_MAP_VH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define OFF_LATCH       12'h000
`define OFF_MASK        12'h004
`define OFF_PENDING     12'h008
`define OFF_CONTROL     12'h00c
`define OFF_PSTATUS_0   12'h010
`define OFF_PSTATUS_1   12'h014
`define OFF_PMASK_0     12'h018
`define OFF_PMASK_1     12'h01c
`define OFF_ROUTE_0     12'h020
`define OFF_ROUTE_6     12'h038

// ---------------------------------------------------------------
// field layout
// ---------------------------------------------------------------
`define NUM_EVENTS      16
`define NUM_PERIPH      56
`define NUM_GP          7
`define GP_FIRST        7
`define GP_GATE_MASK    16'hff80
`define CTRL_GIE_BIT    0
`define ROUTE_FIELD_W   4
`define ROUTE_PER_REG   8

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define RST_LATCH       16'h0000
`define RST_MASK        16'h0000
`define RST_PENDING     16'h0000
`define RST_PMASK       32'h00000000
`define RST_ROUTE_0     32'h00000000
`define RST_ROUTE_1     32'h11000000
`define RST_ROUTE_2     32'h33332222
`define RST_ROUTE_3     32'h44444433
`define RST_ROUTE_4     32'h55555555
`define RST_ROUTE_5     32'h06666655
`define RST_ROUTE_6     32'h33333000

`endif

// *** logic/periph_router.v ***
// routes peripheral requests onto the seven general-purpose levels
`include "event_map.vh"

module periph_router (
   input  wire [55:0]  periph_level,
   input  wire [55:0]  periph_mask,
   input  wire [223:0] route_fields,
   output reg  [6:0]   gp_req
);

   integer i;
   reg [3:0] field;

   // ---------------------------------------------------------------
   // mask then or into the assigned level
   // ---------------------------------------------------------------
   always @* begin
      gp_req = 7'h00;
      field  = 4'h0;
      for (i = 0; i < `NUM_PERIPH; i = i + 1) begin
         field = route_fields[i*`ROUTE_FIELD_W +: `ROUTE_FIELD_W];
         if (periph_level[i] && periph_mask[i] && field < 4'h7) begin
            gp_req[field[2:0]] = 1'b1;
         end
      end
   end

endmodule

// *** logic/rise_detect.v ***
// registered rising-edge detector for event request levels
module rise_detect (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        pce,
   input  wire [15:0] level_in,
   output reg  [15:0] rise_q
);

   reg [15:0] prev_reg;

   // ---------------------------------------------------------------
   // edge detect, one register stage
   // ---------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_reg <= 16'h0000;
         rise_q   <= 16'h0000;
      end else if (pce) begin
         prev_reg <= level_in;
         rise_q   <= level_in & ~prev_reg;
      end
   end

endmodule
